// ===== rtl/eqc_pkg.sv
package eqc_pkg;

  // Number of independent channels
  localparam int NUM_CH = 8;
  localparam int PK_W = 4;
  localparam int GN_W = 2;
  localparam int SW_W = 2;

  // Resolved level of a three-state strap pin
  typedef enum logic [2:0] {
    LVL_LOW  = 3'h1,
    LVL_OPEN = 3'h2,
    LVL_HIGH = 3'h4
  } eqc_level_t;

  // Raw strap pin sensing: drive level and a weak-pull test result
  typedef struct packed {
    logic level;
    logic floating;
  } eqc_strap_t;

  // Controller state
  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_LOAD  = 3'h2,
    ST_RUN   = 3'h4
  } eqc_state_t;

  // One channel's settings
  typedef struct packed {
    logic [PK_W-1:0] peaking;
    logic [GN_W-1:0] gain;
    logic [SW_W-1:0] swing;
  } eqc_chan_t;

  // Host write to one channel's settings
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    eqc_chan_t cfg;
  } eqc_wr_t;

  // Peaking codes, long channel
  localparam logic [PK_W-1:0] PK_LONG_HI = 4'hE;
  localparam logic [PK_W-1:0] PK_LONG_OP = 4'h9;
  localparam logic [PK_W-1:0] PK_LONG_LO = 4'h5;
  // Peaking codes, short channel
  localparam logic [PK_W-1:0] PK_SHORT_HI = 4'h9;
  localparam logic [PK_W-1:0] PK_SHORT_OP = 4'h5;
  localparam logic [PK_W-1:0] PK_SHORT_LO = 4'h3;
  // Gain codes
  localparam logic [GN_W-1:0] GN_LONG_HI = 2'h3;
  localparam logic [GN_W-1:0] GN_LONG_OP = 2'h2;
  localparam logic [GN_W-1:0] GN_LONG_LO = 2'h1;
  localparam logic [GN_W-1:0] GN_SHORT_HI = 2'h2;
  localparam logic [GN_W-1:0] GN_SHORT_OP = 2'h1;
  localparam logic [GN_W-1:0] GN_SHORT_LO = 2'h0;
  // Swing codes
  localparam logic [SW_W-1:0] SW_HI = 2'h3;
  localparam logic [SW_W-1:0] SW_OP = 2'h2;
  localparam logic [SW_W-1:0] SW_LO = 2'h1;

endpackage

// ===== rtl/eqc_pin_strap_config.sv
`timescale 1ns/1ps

// Operation
// - Mode select low gives global pin control, high gives per-channel bus control.
// - Power pin low holds reset, blocks bus traffic, clears all channel settings to zero.
// - Power pin decoded as high, open or low; startup level sets power mode in bus mode, live level in pin mode.
// - Channel-case low or open selects long channel, high selects short channel.
// - Pin mode: swing strap code applied to all channels alike.
// - Pin mode: peaking strap code applied to all channels alike.
// - Pin mode: gain strap code applied to all channels alike.
// - Open cascade input reads as low for address chaining.
// - Cascade output carries address configuration on to the next device.
// - Eight channels each hold their own peaking, gain and swing settings.
// - Bus mode acts as two-wire target on clock input and open-drain data.
// - Peaking map: long E/9/5, short 9/5/3 for high/open/low.
// - Swing map: high 3, open 2, low 1.
// - Power high powers down, open powers on; bus mode only at reset.
module eqc_pin_strap_config (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // Board straps
  input wire logic modeSelect,
  input wire eqc_pkg::eqc_strap_t powerStrap,
  input wire logic channelCase,
  input wire eqc_pkg::eqc_strap_t peaking_strap,
  input wire eqc_pkg::eqc_strap_t gainStrap,
  input wire eqc_pkg::eqc_strap_t swingStrap,
  // Cascade chain
  input wire logic chain_cascade_in,
  output logic chain_cascade_out,
  // Two-wire bus pins
  input wire logic busClkIn,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe,
  // Decoded host write from the bus target core
  input wire eqc_pkg::eqc_wr_t hostWr,
  input wire logic hostDataOut,
  // Bus core shows a received address match
  input wire logic addrDone,
  // Channel settings and status
  output eqc_pkg::eqc_chan_t [eqc_pkg::NUM_CH-1:0] chanCfg,
  output logic chanPowerDown,
  output logic busModeActive,
  output logic busEnabled,
  output logic busClkSeen,
  output logic busDataSeen
);

  // Whole module state
  typedef struct packed {
    eqc_pkg::eqc_state_t st;
    logic busMode;
    logic shortCh;
    logic pwrDown;
    eqc_pkg::eqc_level_t pkLvl;
    eqc_pkg::eqc_level_t gnLvl;
    eqc_pkg::eqc_level_t swLvl;
    eqc_pkg::eqc_chan_t [eqc_pkg::NUM_CH-1:0] cfg;
    logic cascOut;
    logic sdaOut;
    logic sdaOe;
    logic sclSeen;
    logic sdaSeen;
    logic busEn;
  } eqc_state_all_t;

  eqc_state_all_t st_ff;
  eqc_state_all_t nxt_st;
  eqc_pkg::eqc_level_t pwrLvl;
  eqc_pkg::eqc_chan_t strapCfg;

  // Resolve a three-state strap pin
  function automatic eqc_pkg::eqc_level_t resolveLvl(input eqc_pkg::eqc_strap_t s);
    if (s.floating) begin
      resolveLvl = eqc_pkg::LVL_OPEN;
    end else if (s.level) begin
      resolveLvl = eqc_pkg::LVL_HIGH;
    end else begin
      resolveLvl = eqc_pkg::LVL_LOW;
    end
  endfunction

  // Map strap levels, registered or live, to codes for the chosen channel case
  function automatic eqc_pkg::eqc_chan_t strapCodes(input logic sh, input eqc_pkg::eqc_level_t pk,
                                                    input eqc_pkg::eqc_level_t gn,
                                                    input eqc_pkg::eqc_level_t sw);
    eqc_pkg::eqc_chan_t c;
    c = '0;
    case (pk)
      eqc_pkg::LVL_HIGH: c.peaking = sh ? eqc_pkg::PK_SHORT_HI : eqc_pkg::PK_LONG_HI;
      eqc_pkg::LVL_OPEN: c.peaking = sh ? eqc_pkg::PK_SHORT_OP : eqc_pkg::PK_LONG_OP;
      default: c.peaking = sh ? eqc_pkg::PK_SHORT_LO : eqc_pkg::PK_LONG_LO;
    endcase
    case (gn)
      eqc_pkg::LVL_HIGH: c.gain = sh ? eqc_pkg::GN_SHORT_HI : eqc_pkg::GN_LONG_HI;
      eqc_pkg::LVL_OPEN: c.gain = sh ? eqc_pkg::GN_SHORT_OP : eqc_pkg::GN_LONG_OP;
      default: c.gain = sh ? eqc_pkg::GN_SHORT_LO : eqc_pkg::GN_LONG_LO;
    endcase
    case (sw)
      eqc_pkg::LVL_HIGH: c.swing = eqc_pkg::SW_HI;
      eqc_pkg::LVL_OPEN: c.swing = eqc_pkg::SW_OP;
      default: c.swing = eqc_pkg::SW_LO;
    endcase
    strapCodes = c;
  endfunction

  // Power pin level and strap-derived codes
  assign pwrLvl = resolveLvl(powerStrap);
  assign strapCfg = strapCodes(st_ff.shortCh, st_ff.pkLvl, st_ff.gnLvl, st_ff.swLvl);

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclSeen = busClkIn;
    nxt_st.sdaSeen = busDataIn;
    nxt_st.cascOut = chain_cascade_in & addrDone;
    case (st_ff.st)
      eqc_pkg::ST_RESET: begin
        nxt_st.st = eqc_pkg::ST_LOAD;
      end
      eqc_pkg::ST_LOAD: begin
        // Capture straps once after reset release
        nxt_st.busMode = modeSelect;
        nxt_st.shortCh = channelCase;
        nxt_st.pkLvl = resolveLvl(peaking_strap);
        nxt_st.gnLvl = resolveLvl(gainStrap);
        nxt_st.swLvl = resolveLvl(swingStrap);
        nxt_st.pwrDown = (pwrLvl == eqc_pkg::LVL_HIGH);
        nxt_st.st = eqc_pkg::ST_RUN;
      end
      eqc_pkg::ST_RUN: begin
        if (!st_ff.busMode) begin
          // Pin mode: global codes and live power level
          nxt_st.cfg = {eqc_pkg::NUM_CH{strapCfg}};
          nxt_st.pwrDown = (pwrLvl == eqc_pkg::LVL_HIGH);
          nxt_st.sdaOe = 1'b0;
          nxt_st.sdaOut = 1'b0;
        end else begin
          // Bus mode: per-channel host override
          if (hostWr.valid) begin
            nxt_st.cfg[hostWr.chan] = hostWr.cfg;
          end
          nxt_st.sdaOut = 1'b0;
          nxt_st.sdaOe = ~hostDataOut;
        end
      end
      default: nxt_st.st = eqc_pkg::ST_RESET;
    endcase
    // First load cycle seeds per-channel defaults
    if (st_ff.st == eqc_pkg::ST_LOAD) begin
      nxt_st.cfg = {eqc_pkg::NUM_CH{strapCodes(channelCase, resolveLvl(peaking_strap),
                                               resolveLvl(gainStrap), resolveLvl(swingStrap))}};
    end
    // Power pin low forces reset and blocks the bus
    if (pwrLvl == eqc_pkg::LVL_LOW) begin
      nxt_st.st = eqc_pkg::ST_RESET;
      nxt_st.cfg = '0;
      nxt_st.sdaOe = 1'b0;
      nxt_st.cascOut = 1'b0;
    end
    // Bus enable kept in a flop so the output is registered
    nxt_st.busEn = nxt_st.busMode & (nxt_st.st == eqc_pkg::ST_RUN);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '{st: eqc_pkg::ST_RESET, pkLvl: eqc_pkg::LVL_LOW, gnLvl: eqc_pkg::LVL_LOW,
                 swLvl: eqc_pkg::LVL_LOW, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flops
  assign chanCfg = st_ff.cfg;
  assign chanPowerDown = st_ff.pwrDown;
  assign busModeActive = st_ff.busMode;
  assign busEnabled = st_ff.busEn;
  assign busDataOut = st_ff.sdaOut;
  assign busDataOe = st_ff.sdaOe;
  assign chain_cascade_out = st_ff.cascOut;
  assign busClkSeen = st_ff.sclSeen;
  assign busDataSeen = st_ff.sdaSeen;

  // Pin mode copies the strap codes; checked on channels 0 and 5 only
  property p_pin_global;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && pwrLvl != eqc_pkg::LVL_LOW) |=>
        (chanCfg[5] == chanCfg[0]) && (chanCfg[0] == $past(strapCfg));
  endproperty
  a_pin_global: assert property (p_pin_global) else $error("pin mode channels differ");

  property p_peak_code;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && st_ff.pkLvl == eqc_pkg::LVL_HIGH &&
       pwrLvl != eqc_pkg::LVL_LOW) |=> chanCfg[0].peaking == ($past(st_ff.shortCh) ? 4'h9 : 4'hE);
  endproperty
  a_peak_code: assert property (p_peak_code) else $error("peaking code wrong");

  property p_gain_code;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && st_ff.gnLvl == eqc_pkg::LVL_LOW &&
       pwrLvl != eqc_pkg::LVL_LOW) |=> chanCfg[3].gain == ($past(st_ff.shortCh) ? 2'h0 : 2'h1);
  endproperty
  a_gain_code: assert property (p_gain_code) else $error("gain code wrong");

  property p_swing_code;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && st_ff.swLvl == eqc_pkg::LVL_OPEN &&
       pwrLvl != eqc_pkg::LVL_LOW) |=> chanCfg[7].swing == 2'h2;
  endproperty
  a_swing_code: assert property (p_swing_code) else $error("swing code wrong");

  property p_pwr_reset;
    @(posedge mclk) disable iff (rst)
      (pwrLvl == eqc_pkg::LVL_LOW) |=> (chanCfg == '0) && !busDataOe && !busEnabled;
  endproperty
  a_pwr_reset: assert property (p_pwr_reset) else $error("power low did not reset");

  property p_mode_hold;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && pwrLvl != eqc_pkg::LVL_LOW) |=> $stable(busModeActive);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed while running");

  property p_host_write;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && st_ff.busMode && hostWr.valid && pwrLvl != eqc_pkg::LVL_LOW) |=>
        chanCfg[$past(hostWr.chan)] == $past(hostWr.cfg);
  endproperty
  a_host_write: assert property (p_host_write) else $error("host write lost");

  property p_bus_pwr_latched;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && st_ff.busMode && pwrLvl != eqc_pkg::LVL_LOW) |=> $stable(chanPowerDown);
  endproperty
  a_bus_pwr_latched: assert property (p_bus_pwr_latched) else $error("bus mode power changed");

  property p_cascade;
    @(posedge mclk) disable iff (rst)
      (!chain_cascade_in) |=> !chain_cascade_out;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade out without input");

  // Pin mode keeps the bus shut
  property p_pin_bus_off;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode) |=> !busEnabled && !busDataOe;
  endproperty
  a_pin_bus_off: assert property (p_pin_bus_off) else $error("bus active in pin mode");

  // Pin mode power-down follows the live power level
  property p_pin_power;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && pwrLvl != eqc_pkg::LVL_LOW) |=>
        chanPowerDown == ($past(powerStrap.level) && !$past(powerStrap.floating));
  endproperty
  a_pin_power: assert property (p_pin_power) else $error("pin mode power level wrong");

  // Channel case picks the peaking code for an open strap
  property p_peak_case;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && !st_ff.busMode && st_ff.pkLvl == eqc_pkg::LVL_OPEN &&
       pwrLvl != eqc_pkg::LVL_LOW) |=> chanCfg[1].peaking == ($past(st_ff.shortCh) ? 4'h5 : 4'h9);
  endproperty
  a_peak_case: assert property (p_peak_case) else $error("channel case code wrong");

  // Bus mode data enable pulls the line low for each zero bit
  property p_bus_oe;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && st_ff.busMode && pwrLvl != eqc_pkg::LVL_LOW) |=>
        busDataOe == !$past(hostDataOut);
  endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus data enable wrong");

  // Cascade output forwards the input after an address match
  property p_cascade_fwd;
    @(posedge mclk) disable iff (rst)
      (chain_cascade_in && addrDone && pwrLvl != eqc_pkg::LVL_LOW) |=> chain_cascade_out;
  endproperty
  a_cascade_fwd: assert property (p_cascade_fwd) else $error("cascade not forwarded");

  // Channel zero keeps its settings unless written
  property p_chan0_hold;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_RUN && st_ff.busMode && (!hostWr.valid || hostWr.chan != 3'h0) &&
       pwrLvl != eqc_pkg::LVL_LOW) |=> $stable(chanCfg[0]);
  endproperty
  a_chan0_hold: assert property (p_chan0_hold) else $error("unwritten channel changed");

  // Mode select taken at the end of the load step
  property p_mode_capture;
    @(posedge mclk) disable iff (rst)
      (st_ff.st == eqc_pkg::ST_LOAD && pwrLvl != eqc_pkg::LVL_LOW) |=> busModeActive == $past(modeSelect);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode select not captured");

  cov_pin_mode: cover property (@(posedge mclk) disable iff (rst) busEnabled == 1'b0 && st_ff.st == eqc_pkg::ST_RUN);
  cov_bus_write: cover property (@(posedge mclk) disable iff (rst) busEnabled && hostWr.valid);
  cov_pwr_low: cover property (@(posedge mclk) disable iff (rst) pwrLvl == eqc_pkg::LVL_LOW);
  cov_short_case: cover property (@(posedge mclk) disable iff (rst) st_ff.st == eqc_pkg::ST_RUN && st_ff.shortCh);
  cov_bus_pull: cover property (@(posedge mclk) disable iff (rst) busEnabled && busDataOe);

endmodule

// ===== tb/eqc_board_model.sv
`timescale 1ns/1ps

// Board straps and host write source facing the block
module eqc_board_model (
  // Clock
  input wire logic mclk,
  // Straps
  output eqc_pkg::eqc_strap_t powerStrap,
  output eqc_pkg::eqc_strap_t peakStrap,
  output eqc_pkg::eqc_strap_t gainStrap,
  output eqc_pkg::eqc_strap_t swingStrap,
  output logic modeSelect,
  output logic channelCase,
  // Host side
  output eqc_pkg::eqc_wr_t hostWr,
  output logic busClkIn,
  input wire logic busDataOe,
  output logic busDataIn
);
  // Data line has a pull-up; the block pulls it low when enabled
  assign busDataIn = ~busDataOe;

  // Open pin senses as floating, others by level
  function automatic eqc_pkg::eqc_strap_t strap(eqc_pkg::eqc_level_t l);
    return '{level: (l == eqc_pkg::LVL_HIGH), floating: (l == eqc_pkg::LVL_OPEN)};
  endfunction

  // Straps only move while reset is held
  task automatic set_straps(input logic m, input logic c, input eqc_pkg::eqc_level_t pw,
                            input eqc_pkg::eqc_level_t pk);
    modeSelect = m;
    channelCase = c;
    powerStrap = strap(pw);
    peakStrap = strap(pk);
    gainStrap = strap(pk);
    swingStrap = strap(pk);
  endtask

  // Power pin may change at any time
  task automatic set_power(input eqc_pkg::eqc_level_t pw);
    powerStrap = strap(pw);
  endtask

  // Bus clock line as the host drives it
  task automatic set_bus_clk(input logic v);
    busClkIn = v;
  endtask

  // One full channel per write, valid for one cycle
  task automatic write(input logic [2:0] ch, input eqc_pkg::eqc_chan_t c);
    @(negedge mclk);
    hostWr = '{valid: 1'b1, chan: ch, cfg: c};
    @(negedge mclk);
    hostWr.valid = 1'b0;
  endtask

  // Idle bus clock high
  initial begin
    set_straps(1'b0, 1'b0, eqc_pkg::LVL_OPEN, eqc_pkg::LVL_OPEN);
    hostWr = '0;
    busClkIn = 1'b1;
  end
endmodule

// ===== tb/eqc_pin_strap_config_tb_top.sv
`timescale 1ns/1ps

// Self-checking bench for strap and host configuration
module eqc_pin_strap_config_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cascIn = 1'b0;
  logic hostDataOut = 1'b1;
  logic addrDone = 1'b0;
  logic modeSel, chCase, busClk, busData, busOut, busOe, cascOut, pd, busMode, busEn, clkSeen, dataSeen;
  eqc_pkg::eqc_strap_t pwrS, pkS, gnS, swS;
  eqc_pkg::eqc_wr_t hostWr;
  eqc_pkg::eqc_chan_t [eqc_pkg::NUM_CH-1:0] cfg;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  // 250 MHz clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  eqc_board_model BM (.mclk(mclk), .powerStrap(pwrS), .peakStrap(pkS), .gainStrap(gnS), .swingStrap(swS),
    .modeSelect(modeSel), .channelCase(chCase), .hostWr(hostWr), .busClkIn(busClk), .busDataOe(busOe),
    .busDataIn(busData));

  eqc_pin_strap_config DUT (.mclk(mclk), .rst(rst), .modeSelect(modeSel), .powerStrap(pwrS),
    .channelCase(chCase), .peaking_strap(pkS), .gainStrap(gnS), .swingStrap(swS),
    .chain_cascade_in(cascIn), .chain_cascade_out(cascOut), .busClkIn(busClk), .busDataIn(busData),
    .busDataOut(busOut), .busDataOe(busOe), .hostWr(hostWr), .hostDataOut(hostDataOut),
    .addrDone(addrDone), .chanCfg(cfg), .chanPowerDown(pd), .busModeActive(busMode),
    .busEnabled(busEn), .busClkSeen(clkSeen), .busDataSeen(dataSeen));

  // Comparisons
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_cfg(input string n, input eqc_pkg::eqc_chan_t e, input eqc_pkg::eqc_chan_t g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Expected strap code for one level on all three straps
  function automatic eqc_pkg::eqc_chan_t expCfg(input logic s, input eqc_pkg::eqc_level_t l);
    case (l)
      eqc_pkg::LVL_HIGH: return s ? {eqc_pkg::PK_SHORT_HI, eqc_pkg::GN_SHORT_HI, eqc_pkg::SW_HI}
                                  : {eqc_pkg::PK_LONG_HI, eqc_pkg::GN_LONG_HI, eqc_pkg::SW_HI};
      eqc_pkg::LVL_OPEN: return s ? {eqc_pkg::PK_SHORT_OP, eqc_pkg::GN_SHORT_OP, eqc_pkg::SW_OP}
                                  : {eqc_pkg::PK_LONG_OP, eqc_pkg::GN_LONG_OP, eqc_pkg::SW_OP};
      default: return s ? {eqc_pkg::PK_SHORT_LO, eqc_pkg::GN_SHORT_LO, eqc_pkg::SW_LO}
                        : {eqc_pkg::PK_LONG_LO, eqc_pkg::GN_LONG_LO, eqc_pkg::SW_LO};
    endcase
  endfunction

  // Every channel against one expected value, with one exception
  task automatic chk_all(input eqc_pkg::eqc_chan_t e, input int skip);
    for (int ch = 0; ch < eqc_pkg::NUM_CH; ch++) begin
      if (ch != skip) chk_cfg("chanCfg", e, cfg[ch]);
    end
  endtask

  // Reset with straps settled while it is held
  task automatic do_reset(input logic m, input logic c, input eqc_pkg::eqc_level_t pw,
                          input eqc_pkg::eqc_level_t pk);
    @(negedge mclk);
    rst = 1'b1;
    BM.set_straps(m, c, pw, pk);
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  // Pin mode: every case and strap level, host writes ignored
  task automatic t_pin_mode();
    eqc_pkg::eqc_level_t lv[3] = '{eqc_pkg::LVL_LOW, eqc_pkg::LVL_OPEN, eqc_pkg::LVL_HIGH};
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 3; i++) begin
        do_reset(1'b0, c[0], (i == 2) ? eqc_pkg::LVL_HIGH : eqc_pkg::LVL_OPEN, lv[i]);
        chk_all(expCfg(c[0], lv[i]), -1);
        chk_bit("chanPowerDown", i == 2, pd);
        chk_bit("busEnabled", 1'b0, busEn);
        chk_bit("busModeActive", 1'b0, busMode);
        chk_bit("busDataOe", 1'b0, busOe);
        BM.write(3'h3, 8'hFF);
        repeat (2) @(negedge mclk);
        chk_cfg("chanCfg", expCfg(c[0], lv[i]), cfg[3]);
      end
    end
  endtask

  // Bus mode: seeded defaults, independent channels, pin handling, power low
  task automatic t_bus_mode();
    eqc_pkg::eqc_chan_t d = expCfg(1'b1, eqc_pkg::LVL_LOW);
    do_reset(1'b1, 1'b1, eqc_pkg::LVL_OPEN, eqc_pkg::LVL_LOW);
    chk_all(d, -1);
    chk_bit("busModeActive", 1'b1, busMode);
    chk_bit("busEnabled", 1'b1, busEn);
    BM.write(3'h2, 8'hA6);
    BM.write(3'h7, 8'h59);
    repeat (2) @(negedge mclk);
    chk_cfg("chanCfg2", 8'hA6, cfg[2]);
    chk_cfg("chanCfg7", 8'h59, cfg[7]);
    for (int ch = 0; ch < 7; ch++) begin
      if (ch != 2) chk_cfg("chanCfg", d, cfg[ch]);
    end
    BM.set_power(eqc_pkg::LVL_HIGH);
    repeat (3) @(negedge mclk);
    chk_bit("chanPowerDown", 1'b0, pd);
    hostDataOut = 1'b0;
    BM.set_bus_clk(1'b0);
    repeat (2) @(negedge mclk);
    chk_bit("busDataOe", 1'b1, busOe);
    chk_bit("busDataOut", 1'b0, busOut);
    chk_bit("busDataSeen", 1'b0, dataSeen);
    chk_bit("busClkSeen", 1'b0, clkSeen);
    BM.set_power(eqc_pkg::LVL_LOW);
    BM.set_bus_clk(1'b1);
    repeat (2) @(negedge mclk);
    chk_all(8'h00, -1);
    chk_bit("busEnabled", 1'b0, busEn);
    chk_bit("busDataOe", 1'b0, busOe);
    BM.write(3'h1, 8'hC3);
    BM.set_power(eqc_pkg::LVL_OPEN);
    hostDataOut = 1'b1;
    repeat (4) @(negedge mclk);
    chk_all(d, -1);
  endtask

  // Cascade output follows input once the address matched
  task automatic t_cascade();
    cascIn = 1'b1;
    repeat (2) @(negedge mclk);
    chk_bit("chain_cascade_out", 1'b0, cascOut);
    addrDone = 1'b1;
    repeat (2) @(negedge mclk);
    chk_bit("chain_cascade_out", 1'b1, cascOut);
    cascIn = 1'b0;
    repeat (2) @(negedge mclk);
    chk_bit("chain_cascade_out", 1'b0, cascOut);
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    t_pin_mode();
    t_bus_mode();
    t_cascade();
    summarize();
  end
endmodule
